// [ceiu_pkg.sv]
`default_nettype none

package ceiu_pkg;

  // ----------------------------------------------------------------
  // Register offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] CEIU_OFS_CLOCK_CFG = 8'h00;
  localparam logic [7:0] CEIU_OFS_POWER     = 8'h01;
  localparam logic [7:0] CEIU_OFS_INT_CTRL  = 8'h02;
  localparam logic [7:0] CEIU_OFS_MASK_1    = 8'h03;
  localparam logic [7:0] CEIU_OFS_MASK_2    = 8'h04;
  localparam logic [7:0] CEIU_OFS_NOTIF_1   = 8'h05;
  localparam logic [7:0] CEIU_OFS_NOTIF_2   = 8'h06;
  localparam logic [7:0] CEIU_OFS_STATUS    = 8'h07;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int CEIU_BIT_TEST_MODE = 0;
  localparam int CEIU_BIT_SERIAL    = 1;
  localparam int CEIU_BIT_CLOCKING  = 2;
  localparam int CEIU_POS_ADC       = 4;
  localparam int CEIU_POS_DAC       = 8;
  localparam int CEIU_NUM_ADC       = 4;
  localparam int CEIU_NUM_DAC       = 5;
  localparam int CEIU_FLAG_W        = 16;
  localparam int CEIU_ST_MUTED      = 0;
  localparam int CEIU_ST_PD_SEEN    = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [1:0]  CEIU_RST_SPEED_MODE = 2'h0;
  localparam logic [4:0]  CEIU_RST_POWER_DOWN = 5'h1f;
  localparam logic [1:0]  CEIU_RST_INT_PIN    = 2'h0;
  localparam logic [15:0] CEIU_RST_MASK       = 16'h0000;
  localparam logic [15:0] CEIU_RST_FLAGS      = 16'h0000;

  // Interrupt pin configuration: bit 1 open drain, bit 0 active high
  localparam int CEIU_PIN_OPEN_DRAIN  = 1;
  localparam int CEIU_PIN_ACTIVE_HIGH = 0;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } ceiu_bus_req_t;

  typedef enum logic [1:0] {
    CEIU_RUN,
    CEIU_MUTED,
    CEIU_PD_SET
  } ceiu_mute_state_t;

endpackage : ceiu_pkg

`default_nettype wire

// [ceiu_edge_detect.sv]
`default_nettype none

module ceiu_edge_detect #(
  parameter int W = 1
) (
  input  wire logic         clk_sys,
  input  wire logic         reset,
  input  wire logic [W-1:0] level_in,
  output logic      [W-1:0] rise_out
);

  // ----------------------------------------------------------------
  // Rising edge of each source
  // ----------------------------------------------------------------
  logic [W-1:0] prev_q;

  // Starts at zero so a source already high out of reset counts once
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      prev_q <= '0;
    end else begin
      prev_q <= level_in;
    end
  end

  assign rise_out = level_in & ~prev_q;

endmodule : ceiu_edge_detect

`default_nettype wire

// [ceiu_int_pin.sv]
`default_nettype none

module ceiu_int_pin
  import ceiu_pkg::*;
(
  input  wire logic       clk_sys,
  input  wire logic       reset,
  input  wire logic [1:0] pin_cfg,
  input  wire logic       irq,
  output logic            pin_o,
  output logic            pin_oe
);

  // ----------------------------------------------------------------
  // Pin style and polarity
  // ----------------------------------------------------------------
  logic level;
  logic drive_d;
  logic pin_o_q;
  logic pin_oe_q;

  assign level   = pin_cfg[CEIU_PIN_ACTIVE_HIGH] ? irq : ~irq;
  // Open drain only ever pulls low; the pull-up makes the high level
  assign drive_d = pin_cfg[CEIU_PIN_OPEN_DRAIN] ? ~level : 1'b1;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      pin_o_q  <= 1'b1;
      pin_oe_q <= 1'b0;
    end else begin
      pin_o_q  <= pin_cfg[CEIU_PIN_OPEN_DRAIN] ? 1'b0 : level;
      pin_oe_q <= drive_d;
    end
  end

  assign pin_o  = pin_o_q;
  assign pin_oe = pin_oe_q;

endmodule : ceiu_int_pin

`default_nettype wire

// [ceiu_top.sv]
// Summary of operation
// - Flags latch on rising edge of each error
// - Set flag means error happened since clear
// - Test mode entry flags, never mutes outputs
// - Serial port loss flags, mutes until power cycle
// - Rate mismatch or unlock flags, mutes likewise
// - ADC overflow flags per channel, no mute
// - DAC clip flags per channel, no mute
// - Unmasked flag drives interrupt output
// - Mask gates interrupt only, flag still records
// - Two-bit field picks pin polarity and style
// - Open drain or push-pull interrupt pin
// - Notification read sets mask of occurred errors
// - Reset holds every register at default
`default_nettype none

module ceiu_top
  import ceiu_pkg::*;
(
  input  wire logic                clk_sys,
  input  wire logic                reset,
  input  wire ceiu_bus_req_t       bus_req,
  output logic [7:0]               rd_data,
  input  wire logic                test_mode_active,
  input  wire logic                frame_sync_invalid,
  input  wire logic                bit_clock_invalid,
  input  wire logic [1:0]          rate_class_detected,
  input  wire logic                pll_unlocked,
  input  wire logic [3:0]          adc_over_full_scale,
  input  wire logic [4:0]          dac_over_rail,
  output logic [4:0]               channel_power_down,
  output logic [1:0]               speed_mode,
  output logic                     outputs_muted,
  output logic                     int_active,
  output logic                     int_pin_o,
  output logic                     int_pin_oe
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  wire logic wr_clock = bus_req.wr && (bus_req.addr == CEIU_OFS_CLOCK_CFG);
  wire logic wr_power = bus_req.wr && (bus_req.addr == CEIU_OFS_POWER);
  wire logic wr_intc  = bus_req.wr && (bus_req.addr == CEIU_OFS_INT_CTRL);
  wire logic wr_mask1 = bus_req.wr && (bus_req.addr == CEIU_OFS_MASK_1);
  wire logic wr_mask2 = bus_req.wr && (bus_req.addr == CEIU_OFS_MASK_2);
  wire logic rd_ntf1  = bus_req.rd && (bus_req.addr == CEIU_OFS_NOTIF_1);
  wire logic rd_ntf2  = bus_req.rd && (bus_req.addr == CEIU_OFS_NOTIF_2);

  // ----------------------------------------------------------------
  // Control registers
  // ----------------------------------------------------------------
  logic [1:0]  speed_mode_q;
  logic [4:0]  power_down_q;
  logic [1:0]  int_pin_cfg_q;
  logic [15:0] mask_q;
  logic [15:0] mask_d;
  logic [15:0] flag_q;
  logic [15:0] flag_d;
  logic [7:0]  rd_data_q;
  logic [7:0]  rd_data_d;

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      speed_mode_q  <= CEIU_RST_SPEED_MODE;
      power_down_q  <= CEIU_RST_POWER_DOWN;
      int_pin_cfg_q <= CEIU_RST_INT_PIN;
    end else begin
      if (wr_clock) speed_mode_q  <= bus_req.wdata[1:0];
      if (wr_power) power_down_q  <= bus_req.wdata[4:0];
      if (wr_intc)  int_pin_cfg_q <= bus_req.wdata[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Error sources
  // ----------------------------------------------------------------
  logic [11:0] src_level;
  logic [11:0] src_rise;
  logic        rate_mismatch;
  logic [15:0] ev;

  assign rate_mismatch = (rate_class_detected != speed_mode_q) || pll_unlocked;
  assign src_level = {dac_over_rail, adc_over_full_scale, rate_mismatch,
                      frame_sync_invalid | bit_clock_invalid, test_mode_active};

  ceiu_edge_detect #(
    .W (12)
  ) u_edge (
    .clk_sys  (clk_sys),
    .reset    (reset),
    .level_in (src_level),
    .rise_out (src_rise)
  );

  // Same layout as the notification and mask registers
  assign ev = {3'h0, src_rise[11:7], src_rise[6:3], 1'b0, src_rise[2:0]};

  // ----------------------------------------------------------------
  // Notification flags and masks
  // ----------------------------------------------------------------
  function automatic logic [15:0] byte_sel(input logic lo, input logic hi);
    byte_sel = {{8{hi}}, {8{lo}}};
  endfunction : byte_sel

  wire logic [15:0] rd_clr = byte_sel(rd_ntf1, rd_ntf2);
  wire logic [15:0] wr_msk = byte_sel(wr_mask1, wr_mask2);

  // A new event beats the read clear, so nothing is lost
  assign flag_d = (flag_q & ~rd_clr) | ev;
  // Reading a notification byte masks whatever it reports
  assign mask_d = (wr_msk & {bus_req.wdata, bus_req.wdata})
                | (~wr_msk & (mask_q | (flag_q & rd_clr)));

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      flag_q <= CEIU_RST_FLAGS;
      mask_q <= CEIU_RST_MASK;
    end else begin
      flag_q <= flag_d;
      mask_q <= mask_d;
    end
  end

  assign int_active = |(flag_q & ~mask_q);

  // ----------------------------------------------------------------
  // Mute and power-down recovery
  // ----------------------------------------------------------------
  ceiu_mute_state_t state_q;
  ceiu_mute_state_t state_d;
  wire logic fatal_ev = ev[CEIU_BIT_SERIAL] | ev[CEIU_BIT_CLOCKING];
  wire logic all_pd   = &power_down_q;
  wire logic none_pd  = ~|power_down_q;

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      CEIU_RUN:    if (fatal_ev) state_d = CEIU_MUTED;
      CEIU_MUTED:  if (all_pd)   state_d = CEIU_PD_SET;
      CEIU_PD_SET: if (fatal_ev) state_d = CEIU_MUTED;
                   else if (none_pd) state_d = CEIU_RUN;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      state_q <= CEIU_RUN;
    end else begin
      state_q <= state_d;
    end
  end

  assign outputs_muted = (state_q != CEIU_RUN);

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  wire logic [7:0] status_byte = {6'h00, state_q == CEIU_PD_SET, outputs_muted};

  always_comb begin
    rd_data_d = 8'h00;
    unique case (bus_req.addr)
      CEIU_OFS_CLOCK_CFG: rd_data_d = {6'h00, speed_mode_q};
      CEIU_OFS_POWER:     rd_data_d = {3'h0, power_down_q};
      CEIU_OFS_INT_CTRL:  rd_data_d = {6'h00, int_pin_cfg_q};
      CEIU_OFS_MASK_1:    rd_data_d = mask_q[7:0];
      CEIU_OFS_MASK_2:    rd_data_d = mask_q[15:8];
      CEIU_OFS_NOTIF_1:   rd_data_d = flag_q[7:0];
      CEIU_OFS_NOTIF_2:   rd_data_d = flag_q[15:8];
      CEIU_OFS_STATUS:    rd_data_d = status_byte;
      default:            rd_data_d = 8'h00;
    endcase
  end

  // Data stands only in the cycle after the read strobe
  always_ff @(posedge clk_sys) begin
    if (reset) begin
      rd_data_q <= 8'h00;
    end else begin
      rd_data_q <= bus_req.rd ? rd_data_d : 8'h00;
    end
  end

  assign rd_data            = rd_data_q;
  assign channel_power_down = power_down_q;
  assign speed_mode         = speed_mode_q;

  // ----------------------------------------------------------------
  // Interrupt pin
  // ----------------------------------------------------------------
  ceiu_int_pin u_pin (
    .clk_sys (clk_sys),
    .reset   (reset),
    .pin_cfg (int_pin_cfg_q),
    .irq     (int_active),
    .pin_o   (int_pin_o),
    .pin_oe  (int_pin_oe)
  );

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);

  a_flag_on_edge: assert property (
    $rose(test_mode_active) |=> flag_q[CEIU_BIT_TEST_MODE])
    else $error("Test mode edge did not set its flag");

  a_flag_sticky: assert property (
    (flag_q[CEIU_BIT_SERIAL] && !rd_ntf1) |=> flag_q[CEIU_BIT_SERIAL])
    else $error("Flag dropped without a read");

  a_read_clears: assert property (
    (rd_ntf1 && ev[7:0] == 8'h00) |=> flag_q[7:0] == 8'h00)
    else $error("Notification read did not clear flags");

  a_read_masks: assert property (
    rd_ntf2 |=> mask_q[15:8] == ($past(mask_q[15:8]) | $past(flag_q[15:8])))
    else $error("Notification read did not set masks");

  a_mask_no_irq: assert property (
    (mask_q == 16'hffff) |-> !int_active)
    else $error("Masked flag raised the interrupt");

  a_irq_unmasked: assert property (
    (ev[CEIU_POS_DAC] && !mask_q[CEIU_POS_DAC] && !wr_mask2 &&
      !(rd_ntf2 && flag_q[CEIU_POS_DAC])) |=> int_active)
    else $error("Unmasked clip did not raise the interrupt");

  a_serial_mutes: assert property (
    ($rose(frame_sync_invalid) && !$past(bit_clock_invalid)) |=> outputs_muted)
    else $error("Serial port loss did not mute");

  a_mute_holds: assert property (
    (outputs_muted && !none_pd) |=> outputs_muted)
    else $error("Mute released without power-down cycle");

  a_soft_no_mute: assert property (
    (!outputs_muted && !fatal_ev) |=> !outputs_muted)
    else $error("Non-fatal error muted outputs");

  a_cmos_level: assert property (
    (int_pin_cfg_q == 2'h1 && $stable(int_pin_cfg_q)) |=>
      (int_pin_oe && int_pin_o == $past(int_active)))
    else $error("Push-pull active high pin wrong");

  a_od_never_high: assert property (
    (int_pin_cfg_q[CEIU_PIN_OPEN_DRAIN] && $stable(int_pin_cfg_q)) |=>
      !(int_pin_oe && int_pin_o))
    else $error("Open drain pin drove high");

  // Reset overrides the default disable so that the held values are seen
  a_reset_regs: assert property (disable iff (1'b0)
    reset |=> (flag_q == CEIU_RST_FLAGS && mask_q == CEIU_RST_MASK &&
      power_down_q == CEIU_RST_POWER_DOWN && speed_mode_q == CEIU_RST_SPEED_MODE))
    else $error("Reset left a register off its default");

  a_reset_pin: assert property (disable iff (1'b0)
    reset |=> (!int_pin_oe && int_pin_o && !outputs_muted))
    else $error("Reset left the interrupt pin driven");

  a_adc_records: assert property (
    (ev[CEIU_POS_ADC +: CEIU_NUM_ADC] != 4'h0) |=>
      ((flag_q[CEIU_POS_ADC +: CEIU_NUM_ADC] & $past(ev[CEIU_POS_ADC +: CEIU_NUM_ADC]))
        == $past(ev[CEIU_POS_ADC +: CEIU_NUM_ADC])))
    else $error("Overflow event not recorded");

  a_clip_no_mute: assert property (
    (ev[CEIU_POS_DAC +: CEIU_NUM_DAC] != 5'h00 && !fatal_ev && !outputs_muted) |=>
      !outputs_muted)
    else $error("Clip event muted outputs");

  a_clock_mutes: assert property (
    ev[CEIU_BIT_CLOCKING] |=> outputs_muted)
    else $error("Clocking error did not mute");

  a_read_masks_lo: assert property (
    rd_ntf1 |=> mask_q[7:0] == ($past(mask_q[7:0]) | $past(flag_q[7:0])))
    else $error("Low notification read did not set masks");

  a_mute_release: assert property (
    (state_q == CEIU_PD_SET && none_pd && !fatal_ev) |=> !outputs_muted)
    else $error("Power-down cycle did not release mute");

  c_irq_rise:     cover property ($rose(int_active));
  c_mute_exit:    cover property ($fell(outputs_muted));
  c_read_mask:    cover property (rd_ntf1 && |flag_q[7:0] ##1 !int_active);
  c_set_and_read: cover property (rd_ntf1 && ev[CEIU_BIT_CLOCKING]);
  c_od_pull:      cover property (int_pin_cfg_q[CEIU_PIN_OPEN_DRAIN] && int_pin_oe);

endmodule : ceiu_top

`default_nettype wire

// [ceiu_ctrl_model.sv]
`default_nettype none

module ceiu_ctrl_model (
  input  wire logic pin_o,
  input  wire logic pin_oe,
  output logic      int_line
);
  timeunit 1ns;
  timeprecision 100ps;

  // ----------------------------------------------------------------
  // Shared interrupt net
  // ----------------------------------------------------------------
  // Pull-up holds the net high whenever no driver is enabled
  assign int_line = pin_oe ? pin_o : 1'b1;

endmodule : ceiu_ctrl_model

`default_nettype wire

// [test_ceiu_top.sv]
`default_nettype none

module test_ceiu_top;
  import ceiu_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  logic          clk_sys, reset, test_mode_active, frame_sync_invalid;
  logic          bit_clock_invalid, pll_unlocked, outputs_muted, int_active;
  logic          int_pin_o, int_pin_oe, int_line, rd_seen;
  logic [1:0]    rate_class_detected, speed_mode;
  logic [3:0]    adc_over_full_scale;
  logic [4:0]    dac_over_rail, channel_power_down;
  logic [7:0]    rd_data;
  logic [7:0]    exp_q[$];
  ceiu_bus_req_t bus_req;
  int            n_mismatch, checks_done, ch_a, ch_d;

  ceiu_top i_ceiu_top (.clk_sys, .reset, .bus_req, .rd_data, .test_mode_active,
    .frame_sync_invalid, .bit_clock_invalid, .rate_class_detected, .pll_unlocked,
    .adc_over_full_scale, .dac_over_rail, .channel_power_down, .speed_mode,
    .outputs_muted, .int_active, .int_pin_o, .int_pin_oe);
  ceiu_ctrl_model i_ceiu_ctrl_model (.pin_o(int_pin_o), .pin_oe(int_pin_oe), .int_line);

  // ----------------------------------------------------------------
  // Bus and check tasks
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks_done++;
    if (g !== e) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    exp_q.push_back(e);
    @(posedge clk_sys);
  endtask : rd

  // Ends 1 ns past the edge so that outputs have settled
  task automatic idle(input int n);
    bus_req <= '0;
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : idle

  task automatic pin_chk(input logic irq);
    for (int c = 0; c < 4; c++) begin
      wr(CEIU_OFS_INT_CTRL, 8'(c));
      idle(3);
      chk("int_line", (c % 2 == 1) ? irq : !irq, int_line);
      chk("int_pin_oe", (c > 1) ? !int_line : 1'b1, int_pin_oe);
    end
  endtask : pin_chk

  task automatic final_report;
    $display("Comparisons %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  // ----------------------------------------------------------------
  // Clock, read monitor, watchdog
  // ----------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end

  // Read data stands only in the cycle after the strobe
  always @(posedge clk_sys) begin
    if (rd_seen === 1'b1) chk("rd_data", exp_q.pop_front(), rd_data);
    rd_seen = bus_req.rd;
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_mismatch++;
    final_report();
  end

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    bus_req = '0;
    {test_mode_active, frame_sync_invalid, bit_clock_invalid, pll_unlocked} = 4'h0;
    rate_class_detected = 2'h0;
    adc_over_full_scale = 4'h0;
    dac_over_rail = 5'h00;
    void'($urandom(32'h7bbf));
    ch_a = $urandom_range(3, 0);
    ch_d = $urandom_range(4, 0);
    repeat (15) @(posedge clk_sys);
    #1;
    chk("channel_power_down", 8'h1f, channel_power_down);
    chk("int_active", 8'h00, int_active);
    @(posedge clk_sys);
    reset <= 1'b0;
    rd(CEIU_OFS_CLOCK_CFG, 8'h00);
    rd(CEIU_OFS_POWER, 8'h1f);
    rd(CEIU_OFS_INT_CTRL, 8'h00);
    rd(CEIU_OFS_MASK_1, 8'h00);
    rd(CEIU_OFS_NOTIF_2, 8'h00);
    rd(8'h08, 8'h00);
    idle(2);
    pin_chk(1'b0);
    wr(CEIU_OFS_POWER, 8'h00);
    // Test mode held high: one event only
    test_mode_active <= 1'b1;
    idle(4);
    chk("int_active", 8'h01, int_active);
    chk("outputs_muted", 8'h00, outputs_muted);
    rd(CEIU_OFS_NOTIF_1, 8'h01);
    rd(CEIU_OFS_NOTIF_1, 8'h00);
    rd(CEIU_OFS_MASK_1, 8'h01);
    idle(2);
    chk("int_active", 8'h00, int_active);
    test_mode_active <= 1'b0;
    wr(CEIU_OFS_MASK_1, 8'h00);
    // Masked ADC overflow still records
    wr(CEIU_OFS_MASK_1, 8'h10 << ch_a);
    adc_over_full_scale <= 4'h1 << ch_a;
    idle(4);
    chk("int_active", 8'h00, int_active);
    chk("outputs_muted", 8'h00, outputs_muted);
    rd(CEIU_OFS_NOTIF_1, 8'h10 << ch_a);
    adc_over_full_scale <= 4'h0;
    wr(CEIU_OFS_MASK_1, 8'h00);
    // Unmasked DAC clip drives the pin
    dac_over_rail <= 5'h01 << ch_d;
    idle(4);
    chk("int_active", 8'h01, int_active);
    chk("outputs_muted", 8'h00, outputs_muted);
    pin_chk(1'b1);
    rd(CEIU_OFS_NOTIF_2, 8'h01 << ch_d);
    rd(CEIU_OFS_MASK_2, 8'h01 << ch_d);
    dac_over_rail <= 5'h00;
    idle(2);
    chk("int_active", 8'h00, int_active);
    wr(CEIU_OFS_MASK_2, 8'h00);
    // Fatal errors: serial clocks, lock loss, rate mismatch
    for (int s = 0; s < 4; s++) begin
      case (s)
        0: frame_sync_invalid <= 1'b1;
        1: bit_clock_invalid <= 1'b1;
        2: pll_unlocked <= 1'b1;
        default: wr(CEIU_OFS_CLOCK_CFG, 8'h01);
      endcase
      idle(2);
      {frame_sync_invalid, bit_clock_invalid, pll_unlocked} <= 3'h0;
      rate_class_detected <= (s == 3) ? 2'h1 : 2'h0;
      idle(2);
      chk("outputs_muted", 8'h01, outputs_muted);
      chk("int_active", 8'h01, int_active);
      wr(CEIU_OFS_POWER, 8'h00);
      idle(2);
      chk("outputs_muted", 8'h01, outputs_muted);
      wr(CEIU_OFS_POWER, 8'h1f);
      // State moves one edge after the write lands
      idle(1);
      rd(CEIU_OFS_STATUS, 8'h03);
      wr(CEIU_OFS_POWER, 8'h00);
      idle(2);
      chk("outputs_muted", 8'h00, outputs_muted);
      rd(CEIU_OFS_NOTIF_1, (s < 2) ? 8'h02 : 8'h04);
      wr(CEIU_OFS_MASK_1, 8'h00);
    end
    idle(4);
    chk("speed_mode", 8'h01, speed_mode);
    chk("channel_power_down", 8'h00, channel_power_down);
    final_report();
  end

endmodule : test_ceiu_top

`default_nettype wire
